//--- include/lfss_pkg.sv
// Package for the legacy numeric stack state map.
// Assumes one core clock; all indices and layouts below are shared by the design.
package lfss_pkg;

  // ----------------------------------------------------------------------
  // Register file geometry
  // ----------------------------------------------------------------------
  localparam int          FR_W          = 82;
  localparam int          EXP_W         = 17;
  localparam int          SIG_W         = 64;
  localparam int          STACK_N       = 8;
  localparam logic [6:0]  PHYSICAL_FP_REG_FIRST_STACK = 7'h08;
  localparam logic [6:0]  PHYSICAL_FP_REG_LAST_STACK  = 7'h0F;
  localparam int          FR_SIGN_BIT   = 81;
  localparam int          FR_EXP_LSB    = 64;

  // ----------------------------------------------------------------------
  // Exponent encodings of the 82-bit register format
  // ----------------------------------------------------------------------
  localparam logic [16:0] EXP_ZERO       = 17'h00000;
  localparam logic [16:0] EXP_MAX        = 17'h1FFFF;
  localparam logic [16:0] DEFERRED_EXCEPTION_TOKEN_EXP     = 17'h1FFFE;
  localparam logic [16:0] SGL_DENORM_EXP = 17'h0FF81;
  localparam logic [16:0] DBL_DENORM_EXP = 17'h0FC01;
  localparam logic [16:0] SGL_REBIAS     = 17'h0FF80;
  localparam logic [16:0] DBL_REBIAS     = 17'h0FC00;

  // ----------------------------------------------------------------------
  // Application register slots
  // ----------------------------------------------------------------------
  localparam logic [6:0]  APP_REG_CONTROL_SLOT = 7'h15;
  localparam logic [6:0]  APP_REG_STATUS_SLOT  = 7'h1C;

  // ----------------------------------------------------------------------
  // Control register layout
  // ----------------------------------------------------------------------
  localparam int          CTL_CW_W       = 13;
  localparam int          CTL_VEC_LSB    = 32;
  localparam int          VEC_CTL_W      = 16;
  localparam logic [63:0] CTL_RSV_MASK   = 64'hFFFF_0000_FFFF_E000;
  localparam logic [12:0] CW_RESET       = 13'h037F;
  localparam logic [15:0] VEC_CTL_RESET  = 16'h0000;

  // ----------------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------------
  localparam int          ST_FLAGS_LSB   = 0;
  localparam int          FLAGS_W        = 6;
  localparam int          ST_SF_BIT      = 6;
  localparam int          ST_ES_BIT      = 7;
  localparam int          ST_C0_BIT      = 8;
  localparam int          ST_C1_BIT      = 9;
  localparam int          ST_C2_BIT      = 10;
  localparam int          ST_TOP_LSB     = 11;
  localparam int          ST_C3_BIT      = 14;
  localparam int          ST_BUSY_BIT    = 15;
  localparam int          ST_TAG_LSB     = 16;
  localparam int          ST_VFLAGS_LSB  = 32;
  localparam int          FLAG_INVALID   = 0;
  localparam logic [63:0] ST_RSV_MASK    = 64'hFFFF_0040_0000_0000;
  localparam logic [7:0]  EMPTY_RESET    = 8'hFF;

  // ----------------------------------------------------------------------
  // Legacy word layouts and tag classes
  // ----------------------------------------------------------------------
  localparam int          LEG_VEC_CTL_LSB = 16;
  localparam logic [1:0]  TAG_VALID      = 2'h0;
  localparam logic [1:0]  TAG_ZERO       = 2'h1;
  localparam logic [1:0]  TAG_SPECIAL    = 2'h2;
  localparam logic [1:0]  TAG_EMPTY      = 2'h3;

  typedef enum logic [1:0] {
    LSEL_CONTROL,
    LSEL_STATUS,
    LSEL_TAG,
    LSEL_VECTOR
  } lfss_lsel_t;

  typedef enum logic {
    FMT_SINGLE,
    FMT_DOUBLE
  } lfss_fmt_t;

endpackage

//--- design/lfss_fp_convert.sv
// Converts a single or double memory image into the 82-bit register format.
// Assumes a combinational use; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none

module lfss_fp_convert
  import lfss_pkg::*;
(
  input  wire logic      fmt_double_i,
  input  wire logic      normalize_i,
  input  wire logic [63:0] data_i,
  output logic [81:0]    value_o
);

  // ----------------------------------------------------------------------
  // Leading zero count
  // ----------------------------------------------------------------------
  function automatic logic [6:0] lead_zeros(input logic [63:0] v);
    logic [6:0] n;
    logic       found;
    n     = 7'h00;
    found = 1'b0;
    for (int i = SIG_W - 1; i >= 0; i--)
    begin
      if (!found && v[i])
        found = 1'b1;
      else if (!found)
        n = n + 7'h01;
    end
    return n;
  endfunction

  logic        sign;
  logic        exp_zero;
  logic        exp_ones;
  logic [16:0] exp_in;
  logic [16:0] rebias;
  logic [16:0] denorm_exp;
  logic [63:0] frac;
  logic [6:0]  lz;

  always_comb
  begin
    if (fmt_double_i)
    begin
      sign       = data_i[63];
      exp_in     = {6'h00, data_i[62:52]};
      exp_zero   = (data_i[62:52] == 11'h000);
      exp_ones   = (data_i[62:52] == 11'h7FF);
      frac       = {1'b0, data_i[51:0], 11'h000};
      rebias     = DBL_REBIAS;
      denorm_exp = DBL_DENORM_EXP;
    end
    else
    begin
      sign       = data_i[31];
      exp_in     = {9'h000, data_i[30:23]};
      exp_zero   = (data_i[30:23] == 8'h00);
      exp_ones   = (data_i[30:23] == 8'hFF);
      frac       = {1'b0, data_i[22:0], 40'h00_0000_0000};
      rebias     = SGL_REBIAS;
      denorm_exp = SGL_DENORM_EXP;
    end
    lz = lead_zeros(frac);
    if (exp_zero && frac == 64'h0)
      value_o = {sign, EXP_ZERO, 64'h0};
    else if (exp_ones)
      value_o = {sign, EXP_MAX, 1'b1, frac[62:0]};
    else if (exp_zero && normalize_i)
      value_o = {sign, 17'(denorm_exp - {10'h000, lz}), 64'(frac << lz)};
    else if (exp_zero)
      value_o = {sign, denorm_exp, frac};
    else
      value_o = {sign, 17'(exp_in + rebias), 1'b1, frac[62:0]};
  end

endmodule
`default_nettype wire

//--- design/lfss_top.sv
// Legacy numeric stack, control and status state mapped onto the native register file.
// Assumes one core clock, synchronous reset and at most one access per port per cycle.
`timescale 1ns/1ps
`default_nettype none

module lfss_top
  import lfss_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic              native_fr_we_i,
  input  wire logic              native_fr_re_i,
  input  wire logic [6:0]        native_fr_idx_i,
  input  wire logic [FR_W-1:0]   native_fr_wdata_i,
  input  wire logic              legacy_fr_we_i,
  input  wire logic              legacy_fr_re_i,
  input  wire logic [2:0]        legacy_fr_idx_i,
  input  wire logic [FR_W-1:0]   legacy_fr_wdata_i,
  output logic [FR_W-1:0]        fr_rdata_o,
  output logic                   fr_rvalid_o,
  input  wire logic              load_valid_i,
  input  wire logic              load_legacy_i,
  input  wire lfss_fmt_t         load_fmt_i,
  input  wire logic [6:0]        load_idx_i,
  input  wire logic [63:0]       load_data_i,
  input  wire logic              consume_valid_i,
  input  wire logic [2:0]        consume_idx_i,
  output logic                   invalid_operand_fault_o,
  input  wire logic              ar_we_i,
  input  wire logic              ar_re_i,
  input  wire logic [6:0]        ar_num_i,
  input  wire logic [63:0]       ar_wdata_i,
  output logic [63:0]            ar_rdata_o,
  output logic                   reserved_field_fault_o,
  input  wire logic              legacy_wr_i,
  input  wire logic              legacy_rd_i,
  input  wire lfss_lsel_t        legacy_sel_i,
  input  wire logic [31:0]       legacy_wdata_i,
  output logic [31:0]            legacy_rdata_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [STACK_N-1:0][FR_W-1:0] fr;
    logic [CTL_CW_W-1:0]          cw;
    logic [VEC_CTL_W-1:0]         vctl;
    logic [FLAGS_W-1:0]           flags;
    logic                         sf;
    logic [3:0]                   cc;
    logic [2:0]                   top;
    logic [STACK_N-1:0]           empty;
    logic [FLAGS_W-1:0]           vflags;
    logic [FR_W-1:0]              fr_rdata;
    logic                         fr_rvalid;
    logic                         inv_fault;
    logic [63:0]                  ar_rdata;
    logic                         rsv_fault;
    logic [31:0]                  legacy_rdata;
  } lfss_state_t;

  lfss_state_t q;
  lfss_state_t d;
  logic [FR_W-1:0] load_value;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic [2:0] stack_phys(input logic [2:0] n, input logic [2:0] top);
    return 3'(n + top);
  endfunction

  function automatic logic is_stack_reg(input logic [6:0] idx);
    return (idx >= PHYSICAL_FP_REG_FIRST_STACK) && (idx <= PHYSICAL_FP_REG_LAST_STACK);
  endfunction

  function automatic logic [16:0] exp_of(input logic [FR_W-1:0] v);
    return v[FR_EXP_LSB +: EXP_W];
  endfunction

  function automatic logic is_deferred_exception_token(input logic [FR_W-1:0] v);
    return !v[FR_SIGN_BIT] && exp_of(v) == DEFERRED_EXCEPTION_TOKEN_EXP && v[SIG_W-1:0] == 64'h0;
  endfunction

  function automatic logic is_native_denorm(input logic [FR_W-1:0] v);
    return (exp_of(v) == SGL_DENORM_EXP || exp_of(v) == DBL_DENORM_EXP) && !v[SIG_W-1];
  endfunction

  function automatic logic error_summary(input lfss_state_t s);
    return |(s.flags & ~s.cw[FLAGS_W-1:0]);
  endfunction

  function automatic logic [1:0] tag_class(input logic [FR_W-1:0] v, input logic empty);
    if (empty)
      return TAG_EMPTY;
    else if (exp_of(v) == EXP_ZERO && v[SIG_W-1:0] == 64'h0)
      return TAG_ZERO;
    else if (exp_of(v) == EXP_MAX || exp_of(v) == EXP_ZERO || !v[SIG_W-1])
      return TAG_SPECIAL;
    else
      return TAG_VALID;
  endfunction

  function automatic logic [15:0] status_word(input lfss_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[ST_FLAGS_LSB +: FLAGS_W] = s.flags;
    w[ST_SF_BIT]               = s.sf;
    w[ST_ES_BIT]               = error_summary(s);
    w[ST_C0_BIT]               = s.cc[0];
    w[ST_C1_BIT]               = s.cc[1];
    w[ST_C2_BIT]               = s.cc[2];
    w[ST_TOP_LSB +: 3]         = s.top;
    w[ST_C3_BIT]               = s.cc[3];
    w[ST_BUSY_BIT]             = error_summary(s);
    return w;
  endfunction

  function automatic logic [63:0] status_image(input lfss_state_t s);
    logic [63:0] w;
    w = 64'h0;
    w[15:0] = status_word(s);
    for (int i = 0; i < STACK_N; i++)
      w[ST_TAG_LSB + 2 * i] = s.empty[i];
    w[ST_VFLAGS_LSB +: FLAGS_W] = s.vflags;
    return w;
  endfunction

  function automatic logic [63:0] control_image(input lfss_state_t s);
    logic [63:0] w;
    w = 64'h0;
    w[CTL_CW_W-1:0]              = s.cw;
    w[CTL_VEC_LSB +: VEC_CTL_W]  = s.vctl;
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Load conversion
  // ----------------------------------------------------------------------
  lfss_fp_convert u_convert (
    .fmt_double_i (load_fmt_i == FMT_DOUBLE),
    .normalize_i  (load_legacy_i),
    .data_i       (load_data_i),
    .value_o      (load_value)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [FR_W-1:0] used;
    logic [15:0]     tagw;
    used        = '0;
    tagw        = 16'h0000;
    d           = q;
    d.fr_rvalid = 1'b0;
    d.inv_fault = 1'b0;
    d.rsv_fault = 1'b0;

    // Only one entry is written per cycle: load, then native, then legacy.
    // shared stack array
    if (load_valid_i && load_legacy_i)
      d.fr[stack_phys(load_idx_i[2:0], q.top)] = load_value;
    else if (load_valid_i)
    begin
      if (is_stack_reg(load_idx_i))
        d.fr[load_idx_i[2:0]] = load_value;
    end
    else if (native_fr_we_i)
    begin
      if (is_stack_reg(native_fr_idx_i))
        d.fr[native_fr_idx_i[2:0]] = native_fr_wdata_i;
    end
    else if (legacy_fr_we_i)
      d.fr[stack_phys(legacy_fr_idx_i, q.top)] = legacy_fr_wdata_i;

    // Register reads return one cycle after the request.
    if (native_fr_re_i)
    begin
      d.fr_rvalid = 1'b1;
      d.fr_rdata  = is_stack_reg(native_fr_idx_i) ? q.fr[native_fr_idx_i[2:0]] : '0;
    end
    else if (legacy_fr_re_i)
    begin
      d.fr_rvalid = 1'b1;
      d.fr_rdata  = q.fr[stack_phys(legacy_fr_idx_i, q.top)];
    end

    // Native application register accesses.
    if (ar_we_i && ar_num_i == APP_REG_CONTROL_SLOT)
    begin
      if ((ar_wdata_i & CTL_RSV_MASK) != 64'h0)
        d.rsv_fault = 1'b1;
      else
      begin
        d.cw   = ar_wdata_i[CTL_CW_W-1:0];
        d.vctl = ar_wdata_i[CTL_VEC_LSB +: VEC_CTL_W];
      end
    end
    else if (ar_we_i && ar_num_i == APP_REG_STATUS_SLOT)
    begin
      if ((ar_wdata_i & ST_RSV_MASK) != 64'h0)
        d.rsv_fault = 1'b1;
      else
      begin
        d.flags  = ar_wdata_i[ST_FLAGS_LSB +: FLAGS_W];
        d.sf     = ar_wdata_i[ST_SF_BIT];
        d.cc     = {ar_wdata_i[ST_C3_BIT], ar_wdata_i[ST_C2_BIT],
                    ar_wdata_i[ST_C1_BIT], ar_wdata_i[ST_C0_BIT]};
        d.top    = ar_wdata_i[ST_TOP_LSB +: 3];
        for (int i = 0; i < STACK_N; i++)
          d.empty[i] = ar_wdata_i[ST_TAG_LSB + 2 * i];
        d.vflags = ar_wdata_i[ST_VFLAGS_LSB +: FLAGS_W];
      end
    end
    if (ar_re_i && ar_num_i == APP_REG_CONTROL_SLOT)
      d.ar_rdata = control_image(q);
    else if (ar_re_i && ar_num_i == APP_REG_STATUS_SLOT)
      d.ar_rdata = status_image(q);
    else if (ar_re_i)
      d.ar_rdata = 64'h0;

    // Legacy word accesses reach the same fields as the native registers.
    // shared control state
    if (legacy_wr_i)
    begin
      case (legacy_sel_i)
        LSEL_CONTROL:
          d.cw = legacy_wdata_i[CTL_CW_W-1:0];
        LSEL_STATUS:
        begin
          d.flags = legacy_wdata_i[ST_FLAGS_LSB +: FLAGS_W];
          d.sf    = legacy_wdata_i[ST_SF_BIT];
          d.cc    = {legacy_wdata_i[ST_C3_BIT], legacy_wdata_i[ST_C2_BIT],
                     legacy_wdata_i[ST_C1_BIT], legacy_wdata_i[ST_C0_BIT]};
          d.top   = legacy_wdata_i[ST_TOP_LSB +: 3];
        end
        LSEL_TAG:
          for (int i = 0; i < STACK_N; i++)
            d.empty[i] = (legacy_wdata_i[2 * i +: 2] == TAG_EMPTY);
        default:
        begin
          d.vflags = legacy_wdata_i[FLAGS_W-1:0];
          d.vctl   = legacy_wdata_i[LEG_VEC_CTL_LSB +: VEC_CTL_W];
        end
      endcase
    end
    if (legacy_rd_i)
    begin
      case (legacy_sel_i)
        LSEL_CONTROL:
          d.legacy_rdata = {19'h00000, q.cw};
        LSEL_STATUS:
          d.legacy_rdata = {16'h0000, status_word(q)};
        LSEL_TAG:
        begin
          for (int i = 0; i < STACK_N; i++)
            tagw[2 * i +: 2] = tag_class(q.fr[i], q.empty[i]);
          d.legacy_rdata = {16'h0000, tagw};
        end
        default:
          d.legacy_rdata = {q.vctl, 10'h000, q.vflags};
      endcase
    end

    // Legacy operand checks; a raised flag wins over a same-cycle write.
    if (consume_valid_i)
    begin
      used = q.fr[stack_phys(consume_idx_i, q.top)];
      if (is_deferred_exception_token(used))
        d.inv_fault = 1'b1;
      else if (is_native_denorm(used))
        d.inv_fault = 1'b1;
      if (d.inv_fault)
        d.flags[FLAG_INVALID] = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      q        <= '0;
      q.cw     <= CW_RESET;
      q.vctl   <= VEC_CTL_RESET;
      q.empty  <= EMPTY_RESET;
    end
    else
      q <= d;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign fr_rdata_o              = q.fr_rdata;
  assign fr_rvalid_o             = q.fr_rvalid;
  assign invalid_operand_fault_o = q.inv_fault;
  assign ar_rdata_o              = q.ar_rdata;
  assign reserved_field_fault_o  = q.rsv_fault;
  assign legacy_rdata_o          = q.legacy_rdata;

endmodule
`default_nettype wire

//--- test/lfss_properties.sv
// Concurrent checks on the ports of the legacy numeric stack state map.
// Assumes it is bound to lfss_top and shares its clock and synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module lfss_properties
  import lfss_pkg::*;
(
  input  wire logic          clock_i,
  input  wire logic          reset_i,
  input  wire logic          native_fr_re_i,
  input  wire logic          legacy_fr_re_i,
  input  wire logic          fr_rvalid_o,
  input  wire logic          consume_valid_i,
  input  wire logic          invalid_operand_fault_o,
  input  wire logic          ar_we_i,
  input  wire logic          ar_re_i,
  input  wire logic [6:0]    ar_num_i,
  input  wire logic [63:0]   ar_wdata_i,
  input  wire logic [63:0]   ar_rdata_o,
  input  wire logic          reserved_field_fault_o,
  input  wire logic          legacy_rd_i,
  input  wire lfss_lsel_t    legacy_sel_i,
  input  wire logic [31:0]   legacy_rdata_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_rd_answer; native_fr_re_i || legacy_fr_re_i |=> fr_rvalid_o; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_quiet; !native_fr_re_i && !legacy_fr_re_i |=> !fr_rvalid_o; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("spurious read valid");
  property p_ctl_rsv;
    ar_we_i && ar_num_i == APP_REG_CONTROL_SLOT && (ar_wdata_i & CTL_RSV_MASK) != 64'h0
      |=> reserved_field_fault_o;
  endproperty
  a_ctl_rsv: assert property (p_ctl_rsv) else $error("control reserved fault missing");
  property p_st_rsv;
    ar_we_i && ar_num_i == APP_REG_STATUS_SLOT && (ar_wdata_i & ST_RSV_MASK) != 64'h0
      |=> reserved_field_fault_o;
  endproperty
  a_st_rsv: assert property (p_st_rsv) else $error("status reserved fault missing");
  property p_clean_wr;
    ar_we_i && ar_num_i == APP_REG_STATUS_SLOT && (ar_wdata_i & ST_RSV_MASK) == 64'h0
      |=> !reserved_field_fault_o;
  endproperty
  a_clean_wr: assert property (p_clean_wr) else $error("fault on clean status write");
  property p_fault_cause; invalid_operand_fault_o |-> $past(consume_valid_i); endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault without use");
  property p_ar_busy;
    ar_re_i && ar_num_i == APP_REG_STATUS_SLOT |=> ar_rdata_o[15] == ar_rdata_o[7];
  endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("busy differs from summary");
  property p_ar_zero;
    ar_re_i && ar_num_i == APP_REG_STATUS_SLOT
      |=> (ar_rdata_o[47:16] & 32'hFF80_AAAA) == 32'h0;
  endproperty
  a_ar_zero: assert property (p_ar_zero) else $error("ignored bits not zero");
  property p_lw_busy;
    legacy_rd_i && legacy_sel_i == LSEL_STATUS |=> legacy_rdata_o[15] == legacy_rdata_o[7];
  endproperty
  a_lw_busy: assert property (p_lw_busy) else $error("legacy busy differs");
  c_inv: cover property (consume_valid_i ##1 invalid_operand_fault_o);
  c_rsv: cover property (ar_we_i ##1 reserved_field_fault_o);
  c_rd: cover property (legacy_fr_re_i ##1 fr_rvalid_o);
endmodule

bind lfss_top lfss_properties u_props (.clock_i(clock_i), .reset_i(reset_i),
  .native_fr_re_i(native_fr_re_i), .legacy_fr_re_i(legacy_fr_re_i), .fr_rvalid_o(fr_rvalid_o),
  .consume_valid_i(consume_valid_i), .invalid_operand_fault_o(invalid_operand_fault_o),
  .ar_we_i(ar_we_i), .ar_re_i(ar_re_i), .ar_num_i(ar_num_i), .ar_wdata_i(ar_wdata_i),
  .ar_rdata_o(ar_rdata_o), .reserved_field_fault_o(reserved_field_fault_o),
  .legacy_rd_i(legacy_rd_i), .legacy_sel_i(legacy_sel_i), .legacy_rdata_o(legacy_rdata_o));

`default_nettype wire

//--- test/test_legacy_fp_stack_state_map.sv
// Self-checking bench for the legacy numeric stack state map.
// Assumes lfss_top with the checker bound to it; drives all ports itself.
`timescale 1ns/1ps
`default_nettype none

module test_legacy_fp_stack_state_map
  import lfss_pkg::*;
;
  logic            clock_i, reset_i, fr_rvalid_o, invalid_operand_fault_o, reserved_field_fault_o;
  logic            native_fr_we_i, native_fr_re_i, legacy_fr_we_i, legacy_fr_re_i, load_valid_i;
  logic            load_legacy_i, consume_valid_i, ar_we_i, ar_re_i, legacy_wr_i, legacy_rd_i;
  logic [6:0]      native_fr_idx_i, load_idx_i, ar_num_i;
  logic [2:0]      legacy_fr_idx_i, consume_idx_i;
  logic [FR_W-1:0] native_fr_wdata_i, legacy_fr_wdata_i, fr_rdata_o;
  logic [63:0]     load_data_i, ar_wdata_i, ar_rdata_o;
  logic [31:0]     legacy_wdata_i, legacy_rdata_o;
  lfss_fmt_t       load_fmt_i;
  lfss_lsel_t      legacy_sel_i;
  int              errors = 0;
  int              comparisons = 0;

  lfss_top DUT (.clock_i(clock_i), .reset_i(reset_i), .native_fr_we_i(native_fr_we_i),
    .native_fr_re_i(native_fr_re_i), .native_fr_idx_i(native_fr_idx_i),
    .native_fr_wdata_i(native_fr_wdata_i), .legacy_fr_we_i(legacy_fr_we_i),
    .legacy_fr_re_i(legacy_fr_re_i), .legacy_fr_idx_i(legacy_fr_idx_i),
    .legacy_fr_wdata_i(legacy_fr_wdata_i), .fr_rdata_o(fr_rdata_o), .fr_rvalid_o(fr_rvalid_o),
    .load_valid_i(load_valid_i), .load_legacy_i(load_legacy_i), .load_fmt_i(load_fmt_i),
    .load_idx_i(load_idx_i), .load_data_i(load_data_i), .consume_valid_i(consume_valid_i),
    .consume_idx_i(consume_idx_i), .invalid_operand_fault_o(invalid_operand_fault_o),
    .ar_we_i(ar_we_i), .ar_re_i(ar_re_i), .ar_num_i(ar_num_i), .ar_wdata_i(ar_wdata_i),
    .ar_rdata_o(ar_rdata_o), .reserved_field_fault_o(reserved_field_fault_o),
    .legacy_wr_i(legacy_wr_i), .legacy_rd_i(legacy_rd_i), .legacy_sel_i(legacy_sel_i),
    .legacy_wdata_i(legacy_wdata_i), .legacy_rdata_o(legacy_rdata_o));

  always #5 clock_i = ~clock_i;

  // ----------------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [82:0] got, input logic [82:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step();
    @(posedge clock_i);
    #1;
  endtask

  // Application register access; a write checks the fault, a read the data.
  task automatic ar(input logic w, input logic [6:0] n, input logic [63:0] d, input logic ef);
    ar_we_i = w;
    ar_re_i = !w;
    ar_num_i = n;
    ar_wdata_i = d;
    step();
    ar_we_i = 1'b0;
    ar_re_i = 1'b0;
    if (w) chk(83'(reserved_field_fault_o), 83'(ef));
    else chk(83'(ar_rdata_o), 83'(d));
    step();
  endtask

  task automatic lw(input logic w, input lfss_lsel_t s, input logic [31:0] d);
    legacy_wr_i = w;
    legacy_rd_i = !w;
    legacy_sel_i = s;
    legacy_wdata_i = d;
    step();
    legacy_wr_i = 1'b0;
    legacy_rd_i = 1'b0;
    if (!w) chk(83'(legacy_rdata_o), 83'(d));
    step();
  endtask

  // Register file access, native by physical number or legacy by stack index.
  task automatic fr(input logic nat, input logic w, input logic [6:0] i, input logic [81:0] d);
    native_fr_we_i = nat & w;
    native_fr_re_i = nat & !w;
    legacy_fr_we_i = !nat & w;
    legacy_fr_re_i = !nat & !w;
    native_fr_idx_i = i;
    legacy_fr_idx_i = i[2:0];
    native_fr_wdata_i = d;
    legacy_fr_wdata_i = d;
    step();
    {native_fr_we_i, native_fr_re_i, legacy_fr_we_i, legacy_fr_re_i} = 4'h0;
    if (!w) chk({fr_rvalid_o, fr_rdata_o}, {1'b1, d});
    step();
  endtask

  task automatic ld(input logic lg, input lfss_fmt_t f, input logic [6:0] i);
    load_valid_i = 1'b1;
    load_legacy_i = lg;
    load_fmt_i = f;
    load_idx_i = i;
    load_data_i = 64'h1;
    step();
    load_valid_i = 1'b0;
    step();
  endtask

  task automatic cons(input logic [2:0] i, input logic ef);
    consume_valid_i = 1'b1;
    consume_idx_i = i;
    step();
    consume_valid_i = 1'b0;
    chk(83'(invalid_operand_fault_o), 83'(ef));
    step();
  endtask

  task automatic end_sim();
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Test sequence; the status write leaves the stack top at 7
  // ----------------------------------------------------------------------
  initial
  begin
    {clock_i, reset_i, native_fr_we_i, native_fr_re_i, legacy_fr_we_i, legacy_fr_re_i} = 6'h10;
    {load_valid_i, load_legacy_i, consume_valid_i, ar_we_i, ar_re_i, legacy_wr_i} = 6'h00;
    {legacy_rd_i, native_fr_idx_i, load_idx_i, ar_num_i, legacy_fr_idx_i, consume_idx_i} = 28'h0;
    {native_fr_wdata_i, legacy_fr_wdata_i, load_data_i, ar_wdata_i, legacy_wdata_i} = 324'h0;
    load_fmt_i = FMT_SINGLE;
    legacy_sel_i = LSEL_CONTROL;
    repeat (4) @(posedge clock_i);
    #1;
    reset_i = 1'b0;
    step();
    ar(0, APP_REG_CONTROL_SLOT, 64'h037F, 0);
    ar(0, APP_REG_STATUS_SLOT, 64'h5555_0000, 0);
    ar(1, APP_REG_CONTROL_SLOT, 64'h2000, 1);
    ar(1, APP_REG_STATUS_SLOT, 64'h0000_0040_0000_0000, 1);
    ar(1, APP_REG_STATUS_SLOT, 64'h0001_0000_0000_0000, 1);
    lw(0, LSEL_CONTROL, 32'h037F);
    ar(1, APP_REG_STATUS_SLOT, 64'h0000_FFBF_AAAA_3F7F, 0);
    ar(0, APP_REG_STATUS_SLOT, 64'h0000_003F_0000_3F7F, 0);
    lw(1, LSEL_CONTROL, 32'h0370);
    ar(0, APP_REG_CONTROL_SLOT, 64'h0370, 0);
    ar(0, APP_REG_STATUS_SLOT, 64'h0000_003F_0000_BFFF, 0);
    lw(0, LSEL_STATUS, 32'h0000_BFFF);
    lw(0, LSEL_VECTOR, 32'h0000_003F);
    ar(0, 7'h10, 64'h0, 0);
    for (int k = 0; k < 8; k++)
      fr(1, 1, 7'(8 + k), {18'h0, 56'hA5A5_0000_0000_00, 8'(k)});
    for (int k = 0; k < 8; k++)
    begin
      fr(1, 0, 7'(8 + k), {18'h0, 56'hA5A5_0000_0000_00, 8'(k)});
      fr(0, 0, 7'(k), {18'h0, 56'hA5A5_0000_0000_00, 8'((7 + k) % 8)});
    end
    fr(1, 0, 7'h10, 82'h0);
    fr(0, 1, 7'h01, 82'h1_2345);
    fr(1, 0, 7'h08, 82'h1_2345);
    ld(0, FMT_SINGLE, 7'h09);
    fr(1, 0, 7'h09, {1'b0, 17'h0FF81, 64'h0000_0100_0000_0000});
    ld(0, FMT_DOUBLE, 7'h0A);
    fr(1, 0, 7'h0A, {1'b0, 17'h0FC01, 64'h800});
    ld(1, FMT_SINGLE, 7'h00);
    fr(1, 0, 7'h0F, {1'b0, 17'h0FF6A, 64'h8000_0000_0000_0000});
    ld(1, FMT_DOUBLE, 7'h01);
    fr(1, 0, 7'h08, {1'b0, 17'h0FBCD, 64'h8000_0000_0000_0000});
    cons(3'h2, 1);
    fr(1, 1, 7'h0B, {1'b0, 17'h1FFFE, 64'h0});
    cons(3'h4, 1);
    cons(3'h0, 0);
    lw(0, LSEL_TAG, 32'h0000_2AA8);
    lw(1, LSEL_TAG, 32'h0000_C003);
    ar(0, APP_REG_STATUS_SLOT, 64'h0000_003F_4001_BFFF, 0);
    end_sim();
  end

  initial
  begin
    #20000;
    errors++;
    end_sim();
  end
endmodule

`default_nettype wire
